/* File: rtl/slot_geo_address_decode.sv */
// slot pin sampling, parity check and config space base decode
// Behaviour
// - config base value comes from slot pins
// - parity mismatch selects recovery slot thirty
// - parity error may ignore config accesses
// - all pins open selects local switch address
// - base bits seven to three match A23..A19
// - one slot maps one distinct A24 region
// - pins pulled up, levels are inverted slot
`timescale 1ns/10ps
module slot_geo_address_decode
    import slot_geo_pkg::*;
(
    input wire logic clk,
    input wire logic rstn,
    input wire logic [4:0] slot_address_pins, // active low slot pins
    input wire logic slot_parity_pin, // active low parity pin
    input wire logic [4:0] local_switches, // local slot setting
    input wire logic local_enable, // allow switch fallback
    input wire logic ignore_on_error, // drop config accesses on parity error
    input wire logic cyc_valid, // config space cycle present
    input wire logic [23:0] cyc_addr, // cycle address
    output logic [4:0] slot_number, // resolved slot
    output logic [7:0] config_base, // base address value
    output logic parity_error, // slot parity mismatch
    output logic local_used, // switch address in use
    output logic base_valid, // base latched
    output logic config_rom_ctrl_space_hit // cycle claimed
);
    typedef enum logic [1:0] {WAIT_PINS, LATCH, RUN} phase_type;
    phase_type ph_r, ph_nxt; // latch sequence
    logic [5:0] pins_f; // filtered pins
    logic pins_ok; // filter settled
    logic [4:0] slot_raw; // inverted pin levels
    logic par_bad; // odd parity check failed
    logic all_open; // no pin grounded
    logic [4:0] slot_sel; // chosen slot
    // latched results, each except hit_r written only in the latch state
    // and then held until the next reset
    logic [4:0] slot_r, slot_nxt;
    logic perr_r, perr_nxt;
    logic loc_r, loc_nxt;
    logic val_r, val_nxt;
    logic hit_r, hit_nxt;
    logic [7:0] base_r, base_nxt;

    // three-flop filter on the pins, the parity pin rides on top
    // its settled flag only rises once real pin samples have passed through
    slot_pin_sync u_sync (
        .clk(clk),
        .rstn(rstn),
        .pin_in({slot_parity_pin, slot_address_pins}),
        .pin_out(pins_f),
        .settled(pins_ok)
    );

    // pins are grounded for a one, so invert the sensed levels
    always_comb begin
        slot_raw = ~pins_f[4:0];
        all_open = (pins_f[4:0] == PINS_ALL_OPEN);
        // pins plus parity pin carry odd count of ones when sound
        par_bad = ~(^(~pins_f));
        // switch fallback wins: an old backplane leaves every pin open
        // and would otherwise always read as a parity error
        if (all_open && local_enable) begin
            slot_sel = local_switches;
        end else if (par_bad) begin
            slot_sel = RECOVERY_SLOT;
        end else begin
            slot_sel = slot_raw;
        end
    end

    // latch slot once after reset, then decode cycles
    always_comb begin
        ph_nxt = ph_r;
        slot_nxt = slot_r;
        perr_nxt = perr_r;
        loc_nxt = loc_r;
        val_nxt = val_r;
        base_nxt = base_r;
        hit_nxt = 1'b0;
        case (ph_r)
            // hold off until the filter has real pin samples
            WAIT_PINS: begin
                if (pins_ok) begin
                    ph_nxt = LATCH;
                end
            end
            // one cycle: slot, flags and base are taken together
            LATCH: begin
                slot_nxt = slot_sel;
                perr_nxt = par_bad && !(all_open && local_enable);
                loc_nxt = all_open && local_enable;
                base_nxt = BASE_RESET;
                base_nxt[BASE_HI:BASE_LO] = slot_sel;
                val_nxt = 1'b1;
                ph_nxt = RUN;
            end
            // slot fixed now, later pin changes are ignored
            RUN: begin
                // upper address bits must equal the latched base field
                hit_nxt = cyc_valid
                    && (cyc_addr[ADDR_HI:ADDR_LO] == base_r[BASE_HI:BASE_LO])
                    && !(perr_r && ignore_on_error);
            end
            default: begin
                ph_nxt = WAIT_PINS;
            end
        endcase
    end

    // state registers
    // async reset loads constants only, outputs read these directly
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            ph_r <= WAIT_PINS;
            slot_r <= '0;
            perr_r <= 1'b0;
            loc_r <= 1'b0;
            val_r <= 1'b0;
            hit_r <= 1'b0;
            base_r <= BASE_RESET;
        end else begin
            ph_r <= ph_nxt;
            slot_r <= slot_nxt;
            perr_r <= perr_nxt;
            loc_r <= loc_nxt;
            val_r <= val_nxt;
            hit_r <= hit_nxt;
            base_r <= base_nxt;
        end
    end

    // every output is a register, no logic after the flops
    assign slot_number = slot_r;
    assign config_base = base_r;
    assign parity_error = perr_r;
    assign local_used = loc_r;
    assign base_valid = val_r;
    assign config_rom_ctrl_space_hit = hit_r;

    // assertions
    // all on the one clock, silenced while reset is low
    // internal state is watched where the latch step matters
    hit_match_a: assert property (@(posedge clk) disable iff (!rstn)
        config_rom_ctrl_space_hit |-> $past(cyc_addr[ADDR_HI:ADDR_LO]) == slot_number)
        else $error("claim on foreign address");
    hit_gate_a: assert property (@(posedge clk) disable iff (!rstn)
        (parity_error && ignore_on_error) |=> !config_rom_ctrl_space_hit)
        else $error("claim despite parity error");
    recov_slot_a: assert property (@(posedge clk) disable iff (!rstn)
        (parity_error && base_valid) |-> slot_number == RECOVERY_SLOT)
        else $error("parity error without recovery slot");
    base_field_a: assert property (@(posedge clk) disable iff (!rstn)
        base_valid |-> config_base[BASE_HI:BASE_LO] == slot_number)
        else $error("base field mismatch");
    base_hold_a: assert property (@(posedge clk) disable iff (!rstn)
        base_valid |=> $stable(config_base))
        else $error("base changed after latch");
    local_sel_a: assert property (@(posedge clk) disable iff (!rstn)
        (ph_r == LATCH && all_open && local_enable) |=> local_used && slot_number == $past(local_switches))
        else $error("local switch not used");
    pin_sel_a: assert property (@(posedge clk) disable iff (!rstn)
        (ph_r == LATCH && !all_open && !par_bad) |=> slot_number == ~$past(pins_f[4:0]))
        else $error("slot not inverted pins");
    valid_time_a: assert property (@(posedge clk) disable iff (!rstn)
        (ph_r == LATCH) |=> base_valid ##1 base_valid)
        else $error("base not valid after latch");

    // a cycle the block has to claim: latched, matching, not silenced
    sequence cyc_taken_s;
        cyc_valid && base_valid
            && (cyc_addr[ADDR_HI:ADDR_LO] == config_base[BASE_HI:BASE_LO])
            && !(parity_error && ignore_on_error);
    endsequence

    // a cycle the block has to let pass
    sequence cyc_refused_s;
        !cyc_valid || !base_valid
            || (cyc_addr[ADDR_HI:ADDR_LO] != config_base[BASE_HI:BASE_LO])
            || (parity_error && ignore_on_error);
    endsequence

    // first step: the one-cycle latch state
    sequence latch_step_s;
        ph_r == LATCH;
    endsequence

    // then: base valid at once, slot and flag unchanged one cycle on
    sequence latched_s;
        base_valid ##1 (base_valid && $stable(slot_number) && $stable(parity_error));
    endsequence

    // claim follows every matching cycle by exactly one clock
    hit_claim_a: assert property (@(posedge clk) disable iff (!rstn)
        cyc_taken_s |=> config_rom_ctrl_space_hit)
        else $error("matching cycle not claimed");
    // no claim for foreign, early or silenced cycles
    hit_refuse_a: assert property (@(posedge clk) disable iff (!rstn)
        cyc_refused_s |=> !config_rom_ctrl_space_hit)
        else $error("claim on refused cycle");
    // slot is taken in one step and then held
    latch_hold_a: assert property (@(posedge clk) disable iff (!rstn)
        latch_step_s |=> latched_s)
        else $error("latched slot not held");
    // no latch before the filter has seen the real pins
    pin_wait_a: assert property (@(posedge clk) disable iff (!rstn)
        !pins_ok |-> !base_valid)
        else $error("base latched before pins settled");
    // a bad parity count outside the switch case raises the flag
    parity_set_a: assert property (@(posedge clk) disable iff (!rstn)
        (ph_r == LATCH && par_bad && !(all_open && local_enable)) |=> parity_error)
        else $error("parity error not flagged");
    // recovery slot also sits in the base field
    recov_base_a: assert property (@(posedge clk) disable iff (!rstn)
        (parity_error && base_valid) |-> config_base[BASE_HI:BASE_LO] == RECOVERY_SLOT)
        else $error("parity error base not recovery");
    // switch address and parity flag never stand together
    local_excl_a: assert property (@(posedge clk) disable iff (!rstn)
        local_used |-> base_valid && !parity_error)
        else $error("switch address with parity flag");
    // bits below the slot field keep their reset value
    base_low_a: assert property (@(posedge clk) disable iff (!rstn)
        config_base[BASE_LO-1:0] == BASE_RESET[BASE_LO-1:0])
        else $error("base low bits not cleared");
endmodule : slot_geo_address_decode

/* File: rtl/slot_geo_pkg.sv */
// constants for the slot address decode block
package slot_geo_pkg;
    localparam int SLOT_W = 5; // slot number width
    localparam logic [4:0] RECOVERY_SLOT = 5'h1E; // slot 30 fallback address
    localparam logic [4:0] PINS_ALL_OPEN = 5'h1F; // no pin grounded
    localparam int BASE_HI = 7; // base value field top
    localparam int BASE_LO = 3; // base value field bottom
    localparam int ADDR_HI = 23; // config space address top
    localparam int ADDR_LO = 19; // config space address bottom
    localparam int ADDR_W = 24; // config space address width
    localparam logic [7:0] BASE_RESET = 8'h00; // base value after reset
endpackage : slot_geo_pkg

/* File: rtl/slot_pin_sync.sv */
// three-stage synchroniser with agreement filter for slot pins
`timescale 1ns/10ps
module slot_pin_sync
    import slot_geo_pkg::*;
(
    input wire logic clk,
    input wire logic rstn,
    input wire logic [5:0] pin_in, // raw pins, parity on top
    output logic [5:0] pin_out, // filtered level
    output logic settled // filtered level has been updated once
);
    logic [5:0] s1_r, s2_r, s3_r; // synchroniser chain
    logic [2:0] fill_r, fill_nxt; // one bit per stage that holds a real pin sample
    logic [5:0] out_r, out_nxt; // filtered value
    logic set_r, set_nxt; // first agreement seen

    // accept a value only once second and third stages agree
    // the reset fill agrees with itself too, so wait until the chain holds real samples
    always_comb begin
        fill_nxt = {fill_r[1:0], 1'b1};
        out_nxt = out_r;
        set_nxt = set_r;
        if ((&fill_r) && (s2_r == s3_r)) begin
            out_nxt = s3_r;
            set_nxt = 1'b1;
        end
    end

    // chain and filter registers
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            s1_r <= '1;
            s2_r <= '1;
            s3_r <= '1;
            fill_r <= '0;
            out_r <= '1;
            set_r <= 1'b0;
        end else begin
            s1_r <= pin_in;
            s2_r <= s1_r;
            s3_r <= s2_r;
            fill_r <= fill_nxt;
            out_r <= out_nxt;
            set_r <= set_nxt;
        end
    end

    assign pin_out = out_r;
    assign settled = set_r;
endmodule : slot_pin_sync

/* File: testbench/backplane_model.sv */
// backplane slot pins and configuring bus master model
`timescale 1ns/10ps
module backplane_model (
    input wire logic clk,
    input wire logic [4:0] slot, // slot of this position
    input wire logic bad_parity, // wire parity pin wrong
    input wire logic legacy, // old backplane, nothing grounded
    input wire logic hit, // claim from the board
    output logic [4:0] pins, // grounded bit reads low
    output logic parity_pin, // completes odd grounded count
    output logic cyc_valid, // config cycle strobe
    output logic [23:0] cyc_addr // config cycle address
);
    // pulled-up pins read the inverted slot number
    assign pins = legacy ? 5'h1F : ~slot;
    assign parity_pin = legacy ? 1'b1 : (^slot) ^ bad_parity;
    initial begin
        cyc_valid = 1'b0;
        cyc_addr = 24'h00_0000;
    end
    // one config cycle, claim looked at 1 ns after the taking edge
    task automatic probe(input logic [4:0] s, output logic got);
        @(posedge clk);
        #1 cyc_valid = 1'b1;
        cyc_addr = {s, 19'h5_A5A5};
        @(posedge clk);
        #1 cyc_valid = 1'b0;
        // a released bus does not keep its last value
        cyc_addr = ~cyc_addr;
        got = hit;
    endtask : probe
endmodule : backplane_model

/* File: testbench/testbench.sv */
// self-checking bench for the slot address decode block
`timescale 1ns/10ps
module testbench;
    import slot_geo_pkg::*;
    logic clk, rstn, local_enable, ignore_on_error, bad_parity, legacy, got, hit;
    logic parity_pin, cyc_valid, parity_error, local_used, base_valid;
    logic [4:0] slot, local_switches, pins, slot_number;
    logic [23:0] cyc_addr;
    logic [7:0] config_base;
    int miscompares = 0;
    int n_tests = 0;
    // 50 MHz clock
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    slot_geo_address_decode DUT (.clk, .rstn, .slot_address_pins(pins),
        .slot_parity_pin(parity_pin), .local_switches, .local_enable, .ignore_on_error,
        .cyc_valid, .cyc_addr, .slot_number, .config_base, .parity_error, .local_used,
        .base_valid, .config_rom_ctrl_space_hit(hit));
    backplane_model bp (.clk, .slot, .bad_parity, .legacy, .hit, .pins, .parity_pin,
        .cyc_valid, .cyc_addr);
    // single compare for all results, widened to the address size
    task automatic chk(input logic [23:0] g, input logic [23:0] e);
        n_tests++;
        if (g !== e) begin
            miscompares++;
            $display("BAD t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask : chk
    // pins are sensed once per reset, so every test restarts the block
    task automatic restart();
        int i;
        rstn = 1'b0;
        repeat (3) @(posedge clk);
        #1 rstn = 1'b1;
        for (i = 0; i < 20 && base_valid !== 1'b1; i++) @(posedge clk);
        #1 chk(base_valid, 1'b1);
    endtask : restart
    // good parity: base from the pins, only its own region claimed
    task automatic test_good(input logic [4:0] s);
        slot = s;
        bad_parity = 1'b0;
        legacy = 1'b0;
        ignore_on_error = 1'b1;
        restart();
        chk(slot_number, s);
        chk(config_base, {s, 3'b000});
        chk(parity_error, 1'b0);
        bp.probe(s, got);
        chk(got, 1'b1);
        bp.probe(s + 5'h01, got);
        chk(got, 1'b0);
        $display("test good slot %0d done", s);
    endtask : test_good
    // bad parity: recovery slot, claim only if errors are not ignored
    task automatic test_bad(input logic ign);
        slot = 5'h07;
        bad_parity = 1'b1;
        ignore_on_error = ign;
        restart();
        chk(slot_number, RECOVERY_SLOT);
        chk(parity_error, 1'b1);
        chk(config_base, {RECOVERY_SLOT, 3'b000});
        bp.probe(RECOVERY_SLOT, got);
        chk(got, !ign);
        $display("test bad parity ignore %0d done", ign);
    endtask : test_bad
    // old backplane: switches if allowed, else recovery slot with bad parity
    task automatic test_legacy(input logic en);
        legacy = 1'b1;
        bad_parity = 1'b0;
        local_enable = en;
        restart();
        chk(slot_number, en ? local_switches : RECOVERY_SLOT);
        chk(local_used, en);
        chk(parity_error, !en);
        bp.probe(en ? local_switches : RECOVERY_SLOT, got);
        chk(got, en ? 1'b1 : !ignore_on_error);
        $display("test legacy enable %0d done", en);
    endtask : test_legacy
    // counts, verdict and end of run
    task automatic test_done();
        $display("comparisons %0d mismatches %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : test_done
    // hang guard, 2500 cycles, far past the roughly seventy cycles needed
    initial begin
        #50000;
        miscompares++;
        test_done();
    end
    initial begin
        rstn = 1'b0;
        {slot, bad_parity, legacy, local_enable, ignore_on_error} = 9'h000;
        local_switches = 5'h0B;
        @(posedge clk);
        #1 test_good(5'h01);
        test_good(5'h15);
        test_bad(1'b0);
        test_bad(1'b1);
        test_legacy(1'b1);
        test_legacy(1'b0);
        test_done();
    end
endmodule : testbench
